// ---- core/cgs_params.svh ----
// register offsets, field positions and reset values of the clock block
`ifndef CGS_PARAMS_SVH
`define CGS_PARAMS_SVH

`define CGS_AW 8
`define CGS_DW 8

`define CGS_OFF_CLKCTL0 8'h00
`define CGS_OFF_CLKCTL1 8'h04
`define CGS_OFF_PMODE2 8'h08
`define CGS_OFF_PROTECT 8'h0C
`define CGS_OFF_PMODE0 8'h10
`define CGS_OFF_STATUS 8'h14

`define CGS_C0_CLOCK_OUT_PIN_LO 0
`define CGS_C0_CLOCK_OUT_PIN_HI 1
`define CGS_C0_WAIT_STOP 2
`define CGS_C0_SUB_EN 4
`define CGS_C0_MAIN_STOP 5
`define CGS_C0_DIV8 6
`define CGS_C0_SRC_SEL 7

`define CGS_C1_STOP_ENTRY 0
`define CGS_C1_DIV_LO 6
`define CGS_C1_DIV_HI 7

`define CGS_PM2_LOCK 1
`define CGS_PR_CLKREG 0
`define CGS_PR_PMODE 1
`define CGS_PM0_BUS_DIS 7

`define CGS_RST_BUS_DIS 1'b0
`define CGS_RST_DIV_FIELD 2'h0
`define CGS_BOOT_LOAD_CNT 2'h2

`endif

// ---- core/cgs_pkg.sv ----
// types shared by the clock generation block
package cgs_pkg;

    typedef enum logic {
        CGS_SRC_MAIN,
        CGS_SRC_SUB
    } cgs_src_t;

    typedef enum logic [1:0] {
        CGS_CO_OFF,
        CGS_CO_F8,
        CGS_CO_F32,
        CGS_CO_FC
    } cgs_clock_out_pin_t;

endpackage

// ---- core/cgs_clock_gen.sv ----
// clock source select, dividers, gating and protection registers
// Behaviour
// - clock_modify_lock once set stays set until reset
// - lock blocks writes to wait stop, main stop, source select, stop entry
// - boot pin high: cpu clock is main divided by 8, sub osc off
// - stop mode disconnects both oscillator feedback resistors
// - main_osc_stop turns main osc off, output pin high, feedback kept
// - external main clock stops in stop mode, or on main_osc_stop when sub clock is the cpu source
// - stop mode turns off every clock
// - boot pin high: sub osc stopped, feedback open until software enables
// - boot pin low: cpu clock is sub divided by 8, main stopped
// - sub boot resets sub_osc_enable and main_osc_stop to one
// - main source divided by 1, 2, 4, 8 or 16 via div8 and field
// - expansion mode outputs bus clock at cpu rate unless disabled
// - div8 forced on stop entry from main and main stop in low speed
// - f1, f2, f8, f32 and serial clocks from main, converter clock too
// - peripheral clocks gated in wait with stop bit and in low power
// - timer sub clock from sub clock, only while sub osc runs
// - single-chip mode: clock out pin gives f8, f32 or sub rate clock
// - selected cpu clock drives the cpu and the watchdog
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "cgs_params.svh"

module cgs_clock_gen
    import cgs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [`CGS_AW-1:0] addr_i,
    input wire logic [`CGS_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`CGS_DW-1:0] rdata_o,
    input wire logic boot_level_i,
    input wire logic ext_main_clk_i,
    input wire logic main_osc_in_i,
    input wire logic sub_osc_in_i,
    input wire logic proc_mode_exp_i,
    input wire logic wait_mode_i,
    input wire logic wake_i,
    output logic main_osc_out_o,
    output logic sub_osc_out_o,
    output logic main_fb_conn_o,
    output logic sub_fb_conn_o,
    output logic cpu_clk_o,
    output logic busclk_o,
    output logic [3:0] periph_clk_o,
    output logic [3:0] sio_clk_o,
    output logic converter_clk_o,
    output logic timer_subclk_o,
    output logic clock_out_pin_o
);

    // last transition index of one cpu clock half period
    function automatic logic [3:0] cgs_half_last(input logic div8, input logic [1:0] field);
        logic [3:0] r;
        r = 4'h0;
        if (div8) begin
            r = 4'h7;
        end else begin
            unique case (field)
                2'h0: r = 4'h0;
                2'h1: r = 4'h1;
                2'h2: r = 4'h3;
                2'h3: r = 4'hF;
            endcase
        end
        return r;
    endfunction

    logic main_s1_reg, main_s2_reg, main_s3_reg;
    logic sub_s1_reg, sub_s2_reg, sub_s3_reg;
    logic boot_s1_reg, boot_s2_reg, ext_s1_reg, ext_s2_reg;
    logic [1:0] boot_cnt_reg;
    logic boot_done_reg, boot_high_reg;
    logic [1:0] clock_out_pin_sel_reg;
    logic wait_stop_reg, sub_en_reg, main_stop_reg, div8_reg, src_sel_reg;
    logic stop_entry_reg;
    logic [1:0] div_field_reg;
    logic lock_reg, prot_clk_reg, prot_pm_reg, bus_dis_reg;
    logic cpu_clk_reg, bus_en_reg, busclk_reg;
    logic [3:0] cpu_cnt_reg, act_last_reg;
    cgs_src_t act_src_reg;
    logic [4:0] pdiv_reg;
    logic f1_reg, main_out_reg, sub_out_reg, timer_sub_reg, clock_out_pin_reg;
    logic boot_load, wr_c0, wr_c1, wr_pm2, main_run, sub_run, low_power, pgate;
    logic main_edge, main_rise, sub_edge, src_edge, cpu_run;

    // pins pass two flops; the third stage only feeds edge detection
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            main_s1_reg <= 1'b0;
            main_s2_reg <= 1'b0;
            main_s3_reg <= 1'b0;
            sub_s1_reg <= 1'b0;
            sub_s2_reg <= 1'b0;
            sub_s3_reg <= 1'b0;
            boot_s1_reg <= 1'b0;
            boot_s2_reg <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
        end else begin
            main_s1_reg <= main_osc_in_i;
            main_s2_reg <= main_s1_reg;
            main_s3_reg <= main_s2_reg;
            sub_s1_reg <= sub_osc_in_i;
            sub_s2_reg <= sub_s1_reg;
            sub_s3_reg <= sub_s2_reg;
            boot_s1_reg <= boot_level_i;
            boot_s2_reg <= boot_s1_reg;
            ext_s1_reg <= ext_main_clk_i;
            ext_s2_reg <= ext_s1_reg;
        end
    end

    // boot strap caught once the synchroniser holds a valid level
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_cnt_reg <= 2'h0;
            boot_done_reg <= 1'b0;
            boot_high_reg <= 1'b0;
        end else if (!boot_done_reg) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
            if (boot_load) begin
                boot_done_reg <= 1'b1;
                boot_high_reg <= boot_s2_reg;
            end
        end
    end

    assign boot_load = !boot_done_reg && (boot_cnt_reg == `CGS_BOOT_LOAD_CNT);
    assign wr_c0 = wr_i && boot_done_reg && prot_clk_reg && (addr_i == `CGS_OFF_CLKCTL0);
    assign wr_c1 = wr_i && boot_done_reg && prot_clk_reg && (addr_i == `CGS_OFF_CLKCTL1);
    assign wr_pm2 = wr_i && prot_pm_reg && (addr_i == `CGS_OFF_PMODE2);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prot_clk_reg <= 1'b0;
            prot_pm_reg <= 1'b0;
            bus_dis_reg <= `CGS_RST_BUS_DIS;
        end else begin
            if (wr_i && addr_i == `CGS_OFF_PROTECT) begin
                prot_clk_reg <= wdata_i[`CGS_PR_CLKREG];
                prot_pm_reg <= wdata_i[`CGS_PR_PMODE];
            end
            if (wr_i && addr_i == `CGS_OFF_PMODE0) begin
                bus_dis_reg <= wdata_i[`CGS_PM0_BUS_DIS];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_reg <= 1'b0;
        end else if (wr_pm2 && wdata_i[`CGS_PM2_LOCK]) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clock_out_pin_sel_reg <= 2'h0;
            wait_stop_reg <= 1'b0;
            sub_en_reg <= 1'b0;
            main_stop_reg <= 1'b0;
            src_sel_reg <= 1'b0;
            div_field_reg <= `CGS_RST_DIV_FIELD;
        end else if (boot_load) begin
            sub_en_reg <= !boot_s2_reg;
            main_stop_reg <= !boot_s2_reg;
            src_sel_reg <= !boot_s2_reg;
        end else begin
            if (wr_c0) begin
                clock_out_pin_sel_reg <= wdata_i[`CGS_C0_CLOCK_OUT_PIN_HI:`CGS_C0_CLOCK_OUT_PIN_LO];
                sub_en_reg <= wdata_i[`CGS_C0_SUB_EN];
                if (!lock_reg) begin
                    wait_stop_reg <= wdata_i[`CGS_C0_WAIT_STOP];
                    main_stop_reg <= wdata_i[`CGS_C0_MAIN_STOP];
                    src_sel_reg <= wdata_i[`CGS_C0_SRC_SEL];
                end
            end
            if (wr_c1) begin
                div_field_reg <= wdata_i[`CGS_C1_DIV_HI:`CGS_C1_DIV_LO];
            end
        end
    end

    // software sets stop entry, a wake clears it; a same-cycle set wins
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stop_entry_reg <= 1'b0;
        end else if (wr_c1 && !lock_reg && wdata_i[`CGS_C1_STOP_ENTRY]) begin
            stop_entry_reg <= 1'b1;
        end else if (wake_i) begin
            stop_entry_reg <= 1'b0;
        end
    end

    // divide-by-8 cannot be cleared while the main oscillator is stopped
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div8_reg <= 1'b1;
        end else if (wr_c1 && !lock_reg && wdata_i[`CGS_C1_STOP_ENTRY] && !src_sel_reg) begin
            div8_reg <= 1'b1;
        end else if (main_stop_reg) begin
            div8_reg <= 1'b1;
        end else if (wr_c0) begin
            div8_reg <= wdata_i[`CGS_C0_DIV8];
        end
    end

    assign low_power = src_sel_reg && main_stop_reg;
    assign main_run = !stop_entry_reg && !(main_stop_reg && (!ext_s2_reg || src_sel_reg));
    assign sub_run = sub_en_reg && !stop_entry_reg;
    assign main_edge = main_run && (main_s2_reg ^ main_s3_reg);
    assign main_rise = main_run && main_s2_reg && !main_s3_reg;
    assign sub_edge = sub_run && (sub_s2_reg ^ sub_s3_reg);
    assign src_edge = (act_src_reg == CGS_SRC_SUB) ? sub_edge : main_edge;
    assign cpu_run = boot_done_reg && !stop_entry_reg && !wait_mode_i;
    assign pgate = !(stop_entry_reg || low_power || (wait_mode_i && wait_stop_reg));

    assign main_fb_conn_o = !stop_entry_reg;
    assign sub_fb_conn_o = sub_en_reg && !stop_entry_reg;

    // new source and ratio are taken only at a falling edge or while idle low,
    // so every high and low phase has full length
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpu_clk_reg <= 1'b0;
            cpu_cnt_reg <= 4'h0;
            act_src_reg <= CGS_SRC_MAIN;
            act_last_reg <= 4'h7;
        end else if (boot_load) begin
            // strap source taken here, else the first run cycle would use a stale one
            cpu_cnt_reg <= 4'h0;
            act_src_reg <= cgs_src_t'(!boot_s2_reg);
            act_last_reg <= 4'h7;
        end else if (!cpu_clk_reg && !cpu_run) begin
            cpu_cnt_reg <= 4'h0;
            act_src_reg <= cgs_src_t'(src_sel_reg);
            act_last_reg <= cgs_half_last(div8_reg, div_field_reg);
        end else if (src_edge) begin
            if (cpu_cnt_reg == act_last_reg) begin
                cpu_cnt_reg <= 4'h0;
                cpu_clk_reg <= !cpu_clk_reg;
                if (cpu_clk_reg) begin
                    act_src_reg <= cgs_src_t'(src_sel_reg);
                    act_last_reg <= cgs_half_last(div8_reg, div_field_reg);
                end
            end else begin
                cpu_cnt_reg <= cpu_cnt_reg + 4'h1;
            end
        end
    end

    // bus clock enable only moves while cpu and bus clocks are both high,
    // so forcing the pin high never cuts a low phase short
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus_en_reg <= 1'b0;
            busclk_reg <= 1'b1;
        end else begin
            if (cpu_clk_reg && busclk_reg) begin
                bus_en_reg <= proc_mode_exp_i && !bus_dis_reg;
            end
            busclk_reg <= bus_en_reg ? cpu_clk_reg : 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pdiv_reg <= 5'h00;
            f1_reg <= 1'b0;
        end else if (pgate && main_run) begin
            f1_reg <= main_s2_reg;
            if (main_rise) begin
                pdiv_reg <= pdiv_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            main_out_reg <= 1'b0;
            sub_out_reg <= 1'b1;
            timer_sub_reg <= 1'b0;
        end else begin
            main_out_reg <= main_run ? !main_s2_reg : 1'b1;
            sub_out_reg <= sub_run ? !sub_s2_reg : 1'b1;
            timer_sub_reg <= sub_run ? sub_s2_reg : 1'b0;
        end
    end

    // f8 and f32 freeze with the peripheral gate, the sub rate clock does not
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clock_out_pin_reg <= 1'b0;
        end else if (proc_mode_exp_i) begin
            clock_out_pin_reg <= 1'b0;
        end else begin
            unique case (cgs_clock_out_pin_t'(clock_out_pin_sel_reg))
                CGS_CO_OFF: clock_out_pin_reg <= 1'b0;
                CGS_CO_F8: clock_out_pin_reg <= pdiv_reg[2];
                CGS_CO_F32: clock_out_pin_reg <= pdiv_reg[4];
                CGS_CO_FC: clock_out_pin_reg <= timer_sub_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                `CGS_OFF_CLKCTL0: rdata_o <= {src_sel_reg, div8_reg, main_stop_reg, sub_en_reg,
                    1'b0, wait_stop_reg, clock_out_pin_sel_reg};
                `CGS_OFF_CLKCTL1: rdata_o <= {div_field_reg, 5'h00, stop_entry_reg};
                `CGS_OFF_PMODE2: rdata_o <= {6'h00, lock_reg, 1'b0};
                `CGS_OFF_PROTECT: rdata_o <= {6'h00, prot_pm_reg, prot_clk_reg};
                `CGS_OFF_PMODE0: rdata_o <= {bus_dis_reg, 7'h00};
                `CGS_OFF_STATUS: rdata_o <= {2'h0, boot_high_reg, sub_run, main_run,
                    low_power, stop_entry_reg, act_src_reg};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    assign cpu_clk_o = cpu_clk_reg;
    assign busclk_o = busclk_reg;
    assign periph_clk_o = {pdiv_reg[4], pdiv_reg[2], pdiv_reg[0], f1_reg};
    assign sio_clk_o = {pdiv_reg[4], pdiv_reg[2], pdiv_reg[0], f1_reg};
    assign converter_clk_o = f1_reg;
    assign main_osc_out_o = main_out_reg;
    assign sub_osc_out_o = sub_out_reg;
    assign timer_subclk_o = timer_sub_reg;
    assign clock_out_pin_o = clock_out_pin_reg;

    lock_sticky_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        lock_reg |=> lock_reg)
        else $error("lock bit cleared");

    lock_blocks_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (lock_reg && wr_c0 && !boot_load) |=> ($stable(src_sel_reg) && $stable(main_stop_reg)
            && $stable(wait_stop_reg)))
        else $error("locked clock bits changed");

    pm_protect_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (wr_i && addr_i == `CGS_OFF_PMODE2 && !prot_pm_reg && !lock_reg) |=> !lock_reg)
        else $error("unprotected pmode write took effect");

    clk_protect_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (wr_i && addr_i == `CGS_OFF_CLKCTL1 && !prot_clk_reg && boot_done_reg)
            |=> $stable(div_field_reg))
        else $error("unprotected clock write took effect");

    boot_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        boot_load |=> (src_sel_reg == !boot_high_reg) && div8_reg
            && (main_stop_reg == !boot_high_reg) && (sub_en_reg == !boot_high_reg))
        else $error("boot clock selection wrong");

    stop_fb_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        stop_entry_reg |-> (!main_fb_conn_o && !sub_fb_conn_o))
        else $error("feedback connected in stop");

    main_pin_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (main_stop_reg && !ext_s2_reg) |=> main_osc_out_o && main_fb_conn_o == !stop_entry_reg)
        else $error("main output pin not high when stopped");

    cpu_stop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (stop_entry_reg && !cpu_clk_reg) ##1 stop_entry_reg |-> !cpu_clk_reg && !timer_sub_reg)
        else $error("clock toggled in stop");

    div8_force_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        main_stop_reg |=> div8_reg)
        else $error("divide by eight not forced");

    periph_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        !pgate |=> $stable(pdiv_reg) && $stable(f1_reg))
        else $error("peripheral clocks ran while gated");

endmodule

// ---- verif/cgs_osc_model.sv ----
// crystal partner for the main and sub oscillator pins
`timescale 1ns/10ps
module cgs_osc_model #(
    parameter int MAIN_HALF = 5,
    parameter int SUB_HALF = 7
) (
    input wire logic sys_clk_i,
    input wire logic ext_main_clk_i,
    input wire logic main_osc_out_i,
    input wire logic main_fb_conn_i,
    input wire logic sub_fb_conn_i,
    output logic main_osc_in_o,
    output logic sub_osc_in_o
);
    int mc = 0;
    int sc = 0;
    int hc = 0;
    logic mph = 1'b0, sph = 1'b0, mrel = 1'b0, srel = 1'b0;
    initial main_osc_in_o = 1'b0;
    initial sub_osc_in_o = 1'b0;
    always @(posedge sys_clk_i) begin
        hc <= main_osc_out_i ? hc + 1 : 0;
        mc <= (mc == MAIN_HALF - 1) ? 0 : mc + 1;
        sc <= (sc == SUB_HALF - 1) ? 0 : sc + 1;
        if (mc == MAIN_HALF - 1) mph <= ~mph;
        if (sc == SUB_HALF - 1) sph <= ~sph;
    end
    // external source keeps running whatever the pins do
    always @(posedge sys_clk_i) begin
        mrel <= !main_fb_conn_i && !ext_main_clk_i;
        if (ext_main_clk_i) main_osc_in_o <= mph;
        else if (!main_fb_conn_i) main_osc_in_o <= mrel ? main_osc_in_o : ~main_osc_in_o;
        else if (hc > MAIN_HALF + 4) main_osc_in_o <= 1'b1;
        else main_osc_in_o <= mph;
    end
    // released sub pin shows the inverse of its last level, then holds
    always @(posedge sys_clk_i) begin
        srel <= !sub_fb_conn_i;
        if (sub_fb_conn_i) sub_osc_in_o <= sph;
        else sub_osc_in_o <= srel ? sub_osc_in_o : ~sub_osc_in_o;
    end
endmodule

// ---- verif/clock_generation_and_select_tb.sv ----
// self-checking bench for the clock generation block
`timescale 1ns/10ps
`include "cgs_params.svh"
module clock_generation_and_select_tb
    import cgs_pkg::*;
;
    localparam int MH = 5;
    localparam int SH = 7;
    localparam logic [7:0] C0 = `CGS_OFF_CLKCTL0;
    localparam logic [7:0] C1 = `CGS_OFF_CLKCTL1;
    localparam logic [7:0] PM2 = `CGS_OFF_PMODE2;
    localparam logic [7:0] PR = `CGS_OFF_PROTECT;
    localparam logic [7:0] PM0 = `CGS_OFF_PMODE0;
    localparam logic [7:0] ST = `CGS_OFF_STATUS;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
    logic boot_level_i = 1'b1, ext_main_clk_i = 1'b0, proc_mode_exp_i = 1'b0;
    logic wait_mode_i = 1'b0, wake_i = 1'b0;
    wire logic [7:0] rdata_o;
    wire logic [3:0] periph_clk_o, sio_clk_o;
    wire logic main_osc_in_i, sub_osc_in_i, main_osc_out_o, sub_osc_out_o;
    wire logic main_fb_conn_o, sub_fb_conn_o, cpu_clk_o, busclk_o;
    wire logic converter_clk_o, timer_subclk_o, clock_out_pin_o;
    wire logic [9:0] mon = {sio_clk_o[0], busclk_o, clock_out_pin_o, timer_subclk_o,
                            converter_clk_o, periph_clk_o, cpu_clk_o};
    int mismatches = 0;
    int num_checks = 0;
    int ratio[4] = '{1, 2, 4, 16};
    cgs_clock_out_pin_t co[3] = '{CGS_CO_F8, CGS_CO_F32, CGS_CO_FC};
    int co_per[3] = '{16 * MH, 64 * MH, 2 * SH};

    always #10 sys_clk_i = ~sys_clk_i;

    cgs_clock_gen dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .boot_level_i(boot_level_i), .ext_main_clk_i(ext_main_clk_i),
        .main_osc_in_i(main_osc_in_i), .sub_osc_in_i(sub_osc_in_i),
        .proc_mode_exp_i(proc_mode_exp_i), .wait_mode_i(wait_mode_i), .wake_i(wake_i),
        .main_osc_out_o(main_osc_out_o), .sub_osc_out_o(sub_osc_out_o),
        .main_fb_conn_o(main_fb_conn_o), .sub_fb_conn_o(sub_fb_conn_o),
        .cpu_clk_o(cpu_clk_o), .busclk_o(busclk_o), .periph_clk_o(periph_clk_o),
        .sio_clk_o(sio_clk_o), .converter_clk_o(converter_clk_o),
        .timer_subclk_o(timer_subclk_o), .clock_out_pin_o(clock_out_pin_o));

    cgs_osc_model #(.MAIN_HALF(MH), .SUB_HALF(SH)) osc (.sys_clk_i(sys_clk_i),
        .ext_main_clk_i(ext_main_clk_i), .main_osc_out_i(main_osc_out_o),
        .main_fb_conn_i(main_fb_conn_o), .sub_fb_conn_i(sub_fb_conn_o),
        .main_osc_in_o(main_osc_in_i), .sub_osc_in_o(sub_osc_in_i));

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic bad(input string nm, input logic [31:0] e, input logic [31:0] g);
        mismatches++;
        $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        g = rdata_o;
        num_checks++;
        if (g !== e) bad(nm, e, g);
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) bad(nm, e, g);
    endtask

    // cycles to the next rising edge of a watched clock; above 1000 means frozen
    task automatic rise(input int s, output int n);
        logic pv;
        n = 0;
        pv = mon[s];
        forever begin
            @(negedge sys_clk_i);
            n = n + 1;
            if ((pv === 1'b0 && mon[s] === 1'b1) || n > 1000) break;
            pv = mon[s];
        end
    endtask

    // first interval may straddle a ratio change, so the third one counts
    task automatic per_chk(input string nm, input int s, input int e);
        int n;
        int p;
        // a clock being frozen may still finish its last phase first
        if (e == 0) begin
            repeat (200) @(posedge sys_clk_i);
        end
        rise(s, n);
        p = n;
        if (e != 0) begin
            rise(s, n);
            rise(s, p);
        end
        if (p > 1000) p = 0;
        num_checks++;
        if (p != e) bad(nm, e, p);
    endtask

    initial begin
        #1000000;
        mismatches++;
        results();
    end

    task automatic do_reset(input logic b);
        @(posedge sys_clk_i);
        rstn_i <= 1'b0;
        boot_level_i <= b;
        repeat (20) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
    endtask

    initial begin
        do_reset(1'b1);
        rd_chk("status", ST, 8'h28);
        rd_chk("clkctl0", C0, 8'h40);
        chk1("sub_fb", 1'b0, sub_fb_conn_o);
        chk1("sub_out", 1'b1, sub_osc_out_o);
        per_chk("cpu", 0, 16 * MH);
        per_chk("timer_sub", 6, 0);
        per_chk("f1", 1, 2 * MH);
        per_chk("f2", 2, 4 * MH);
        per_chk("f8", 3, 16 * MH);
        per_chk("f32", 4, 64 * MH);
        per_chk("conv", 5, 2 * MH);
        per_chk("sio1", 9, 2 * MH);
        wr(C0, 8'h00);
        rd_chk("clkctl0", C0, 8'h40);
        wr(PR, 8'h01);
        wr(PM2, 8'h02);
        rd_chk("pmode2", PM2, 8'h00);
        wr(C0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(C1, 8'(i << 6));
            per_chk("cpu", 0, 2 * MH * ratio[i]);
        end
        @(posedge sys_clk_i);
        proc_mode_exp_i <= 1'b1;
        per_chk("bus", 8, 32 * MH);
        wr(PM0, 8'h80);
        per_chk("bus", 8, 0);
        chk1("bus", 1'b1, busclk_o);
        wr(PM0, 8'h00);
        proc_mode_exp_i <= 1'b0;
        wr(C1, 8'h00);
        wr(C0, 8'h10);
        repeat (200) @(posedge sys_clk_i);
        per_chk("timer_sub", 6, 2 * SH);
        for (int i = 0; i < 3; i++) begin
            wr(C0, 8'h10 | 8'(co[i]));
            per_chk("clock_out_pin", 7, co_per[i]);
        end
        wr(C0, 8'h10 | 8'(CGS_CO_OFF));
        per_chk("clock_out_pin", 7, 0);
        chk1("clock_out_pin", 1'b0, clock_out_pin_o);
        @(posedge sys_clk_i);
        wait_mode_i <= 1'b1;
        per_chk("f1", 1, 2 * MH);
        wr(C0, 8'h14);
        per_chk("f1", 1, 0);
        per_chk("timer_sub", 6, 2 * SH);
        @(posedge sys_clk_i);
        wait_mode_i <= 1'b0;
        wr(C0, 8'h90);
        per_chk("cpu", 0, 2 * SH);
        wr(C0, 8'hB0);
        rd_chk("clkctl0", C0, 8'hF0);
        per_chk("f1", 1, 0);
        chk1("main_out", 1'b1, main_osc_out_o);
        chk1("main_fb", 1'b1, main_fb_conn_o);
        per_chk("cpu", 0, 16 * SH);
        wr(C0, 8'hD0);
        repeat (200) @(posedge sys_clk_i);
        wr(C0, 8'h50);
        per_chk("cpu", 0, 16 * MH);
        @(posedge sys_clk_i);
        ext_main_clk_i <= 1'b1;
        wr(C0, 8'h70);
        per_chk("f1", 1, 2 * MH);
        @(posedge sys_clk_i);
        ext_main_clk_i <= 1'b0;
        wr(C0, 8'h10);
        wr(C1, 8'h01);
        rd_chk("clkctl0", C0, 8'h50);
        chk1("main_fb", 1'b0, main_fb_conn_o);
        chk1("sub_fb", 1'b0, sub_fb_conn_o);
        per_chk("cpu", 0, 0);
        per_chk("timer_sub", 6, 0);
        @(posedge sys_clk_i);
        wake_i <= 1'b1;
        @(posedge sys_clk_i);
        wake_i <= 1'b0;
        per_chk("f1", 1, 2 * MH);
        do_reset(1'b0);
        rd_chk("clkctl0", C0, 8'hF0);
        rd_chk("status", ST, 8'h15);
        per_chk("cpu", 0, 16 * SH);
        chk1("main_out", 1'b1, main_osc_out_o);
        wr(PR, 8'h03);
        wr(PM2, 8'h02);
        wr(PM2, 8'h00);
        rd_chk("pmode2", PM2, 8'h02);
        wr(C0, 8'h75);
        rd_chk("clkctl0", C0, 8'hF1);
        wr(C1, 8'h01);
        rd_chk("status", ST, 8'h15);
        results();
    end
endmodule
